// ==== tocu_map.vh ====
// Constants for the three-channel timer output compare unit.
// Assumes inclusion by bare name from the design files.
`ifndef TOCU_MAP_VH
`define TOCU_MAP_VH

////////////////////////////////////////////////////////////////////////////////
// Waveform mode select codes
`define TOCU_WAVE_NORMAL 4'h0
`define TOCU_WAVE_PC8 4'h1
`define TOCU_WAVE_PC9 4'h2
`define TOCU_WAVE_PC10 4'h3
`define TOCU_WAVE_CLEAR_CMP 4'h4
`define TOCU_WAVE_FAST8 4'h5
`define TOCU_WAVE_FAST9 4'h6
`define TOCU_WAVE_FAST10 4'h7
`define TOCU_WAVE_PFC_CAP 4'h8
`define TOCU_WAVE_PFC_CMP 4'h9
`define TOCU_WAVE_PC_CAP 4'ha
`define TOCU_WAVE_PC_CMP 4'hb
`define TOCU_WAVE_CLEAR_CAP 4'hc
`define TOCU_WAVE_RESERVED 4'hd
`define TOCU_WAVE_FAST_CAP 4'he
`define TOCU_WAVE_FAST_CMP 4'hf

////////////////////////////////////////////////////////////////////////////////
// Output action mode codes
`define TOCU_ACT_OFF 2'h0
`define TOCU_ACT_TOGGLE 2'h1
`define TOCU_ACT_CLEAR 2'h2
`define TOCU_ACT_SET 2'h3

////////////////////////////////////////////////////////////////////////////////
// Widths and reset values
`define TOCU_CHANNELS 3
`define TOCU_WIDTH 16
`define TOCU_BYTE 8
`define TOCU_COMPARE_RESET 16'h0000
`define TOCU_TEMP_RESET 8'h00
`define TOCU_STATE_RESET 1'b0
`define TOCU_COUNTER_MAX 16'hffff

`endif

// ==== tocu_mode_decode.v ====
// Decodes the waveform mode select field into the classes the compare unit needs.
// Assumes the mode field is a stable level from a control register.
`timescale 1ns/1ns
`default_nettype none
`include "tocu_map.vh"

module tocu_mode_decode (
   input wire [3:0] waveform_mode_select,
   output reg is_pwm,
   output reg is_fast,
   output reg is_phase,
   output reg update_at_top,
   output reg toggle_allowed
);

   ////////////////////////////////////////////////////////////////////////////
   // The reserved code is treated as non-PWM so the force strobe still works
   always @* begin
      is_fast = 1'b0;
      is_phase = 1'b0;
      update_at_top = 1'b0;
      toggle_allowed = 1'b0;
      case (waveform_mode_select)
         `TOCU_WAVE_PC8, `TOCU_WAVE_PC9, `TOCU_WAVE_PC10, `TOCU_WAVE_PC_CAP: begin
            is_phase = 1'b1;
            update_at_top = 1'b1;
         end
         `TOCU_WAVE_PC_CMP: begin
            is_phase = 1'b1;
            update_at_top = 1'b1;
            toggle_allowed = 1'b1;
         end
         `TOCU_WAVE_PFC_CAP: begin
            is_phase = 1'b1;
         end
         `TOCU_WAVE_PFC_CMP: begin
            is_phase = 1'b1;
            toggle_allowed = 1'b1;
         end
         `TOCU_WAVE_FAST8, `TOCU_WAVE_FAST9, `TOCU_WAVE_FAST10: begin
            is_fast = 1'b1;
         end
         `TOCU_WAVE_FAST_CAP, `TOCU_WAVE_FAST_CMP: begin
            is_fast = 1'b1;
            toggle_allowed = 1'b1;
         end
         default: begin
            is_fast = 1'b0;
         end
      endcase
      is_pwm = is_fast | is_phase;
   end

endmodule
`default_nettype wire

// ==== tocu_pin_mux.v ====
// Port override for the compare output pins.
// Assumes the general port value and direction bits come from the port block.
`timescale 1ns/1ns
`default_nettype none
`include "tocu_map.vh"

module tocu_pin_mux #(
   parameter CHANNELS = `TOCU_CHANNELS
) (
   input wire [2*CHANNELS-1:0] output_action_mode,
   input wire [CHANNELS-1:0] channel_output_state,
   input wire [CHANNELS-1:0] port_output_value,
   input wire [CHANNELS-1:0] pin_direction_bit,
   output wire [CHANNELS-1:0] pin_out,
   output wire [CHANNELS-1:0] pin_oe
);

   genvar i;
   generate
      for (i = 0; i < CHANNELS; i = i + 1) begin : g_pin
         // Either mode bit hands the pin value to the compare unit
         assign pin_out[i] = (|output_action_mode[2*i+1:2*i]) ? channel_output_state[i] :
                             port_output_value[i]; // [R16]
         // Direction stays with the port, so the state only shows when driven
         assign pin_oe[i] = pin_direction_bit[i]; // [R16] [R17]
      end
   endgenerate

endmodule
`default_nettype wire

// ==== tocu_output_compare.v ====
// Three-channel output compare unit of a 16-bit timer/counter.
// Assumes the counter, its tick, top and bottom flags and direction come from outside,
// and that CPU byte writes arrive as one-cycle strobes on the system clock.
//
// Operation
// [R1] Three independent channels, each with compare value, force, state and mode.
// [R2] Compare value double-buffered in all PWM modes, direct in normal and clear-on-match.
// [R3] Buffered value moves to the active register only at top or bottom.
// [R4] CPU writes reach the buffer when buffering, otherwise the active register.
// [R5] Only CPU writes change the compare value; high byte reads come direct.
// [R6] High byte goes to shared temporary byte; low write loads all 16 bits.
// [R7] Force strobe in non-PWM modes updates the state as a real match would.
// [R8] Forced compare sets no match flag and does not clear the counter.
// [R9] Counter write blocks every compare match in the next timer cycle.
// [R10] Counter written equal to variable top misses top, counts to maximum.
// [R11] Software should not load bottom while counting down.
// [R12] Software should initialise the state before making the pin an output.
// [R13] Output state keeps its value across waveform mode changes.
// [R14] Output mode field is not buffered and governs the next match.
// [R15] Reset clears every channel output state to zero.
// [R16] Nonzero mode field replaces the port value; direction follows the port.
// [R17] Channel state reaches the pin only while direction selects output.
// [R18] Mode field zero changes nothing on a match in any waveform mode.
// [R19] Non-PWM actions: 00 none, 01 toggle, 10 clear, 11 set.
// [R20] Mode field has no influence on input capture.
// [R21] A match sets the channel match flag on the following timer cycle.
// [R22] Force strobe holds no state and reads as zero.
`timescale 1ns/1ns
`default_nettype none
`include "tocu_map.vh"

module tocu_output_compare #(
   parameter CHANNELS = `TOCU_CHANNELS
) (
   input wire clk,
   input wire reset_n,
   input wire [`TOCU_WIDTH-1:0] counter_value,
   input wire counter_tick,
   input wire counter_write,
   input wire counter_at_top,
   input wire counter_at_bottom,
   input wire counter_down,
   input wire [3:0] waveform_mode_select,
   input wire [2*CHANNELS-1:0] output_action_mode,
   input wire [CHANNELS-1:0] force_match_strobe,
   input wire cpu_write_high,
   input wire [CHANNELS-1:0] cpu_write_low,
   input wire [`TOCU_BYTE-1:0] cpu_write_data,
   input wire [CHANNELS-1:0] match_flag_clear,
   input wire [CHANNELS-1:0] port_output_value,
   input wire [CHANNELS-1:0] pin_direction_bit,
   output wire [`TOCU_WIDTH*CHANNELS-1:0] compare_read,
   output wire [`TOCU_WIDTH*CHANNELS-1:0] compare_active,
   output wire [CHANNELS-1:0] force_read,
   output reg [CHANNELS-1:0] match_flag,
   output reg [CHANNELS-1:0] match_event,
   output reg [CHANNELS-1:0] channel_output_state,
   output wire [CHANNELS-1:0] pin_out,
   output wire [CHANNELS-1:0] pin_oe
);

   ////////////////////////////////////////////////////////////////////////////
   // Mode decode
   wire is_pwm;
   wire is_fast;
   wire is_phase;
   wire update_at_top;
   wire toggle_allowed;

   tocu_mode_decode u_decode (
      .waveform_mode_select(waveform_mode_select),
      .is_pwm(is_pwm),
      .is_fast(is_fast),
      .is_phase(is_phase),
      .update_at_top(update_at_top),
      .toggle_allowed(toggle_allowed)
   );

   // Buffering follows the mode; the mode field plays no part here
   wire buffered = is_pwm; // [R2]

   // Transfer instants are timer ticks at top or bottom only
   wire update_point = counter_tick & (update_at_top ? counter_at_top : counter_at_bottom); // [R3]
   wire bottom_event = counter_tick & counter_at_bottom;

   ////////////////////////////////////////////////////////////////////////////
   // Shared temporary high byte
   reg [`TOCU_BYTE-1:0] temp_high;

   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         temp_high <= `TOCU_TEMP_RESET;
      end else if (cpu_write_high) begin
         temp_high <= cpu_write_data; // [R6]
      end
   end

   // Whole word seen by the low-byte write in a single cycle
   wire [`TOCU_WIDTH-1:0] write_word = {temp_high, cpu_write_data}; // [R6]

   ////////////////////////////////////////////////////////////////////////////
   // Match blocking after a counter write
   // The block waits for the next tick even while the counter is stopped
   reg block_pending;

   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         block_pending <= 1'b0;
      end else if (counter_write) begin
         block_pending <= 1'b1; // [R9]
      end else if (counter_tick) begin
         block_pending <= 1'b0; // [R9]
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Compare channels
   genvar i;
   generate
      for (i = 0; i < CHANNELS; i = i + 1) begin : g_chan // [R1]
         reg [`TOCU_WIDTH-1:0] buffer_value;
         reg [`TOCU_WIDTH-1:0] active_value;
         reg pending;
         reg next_state;
         wire [1:0] action;
         wire hit;
         wire force_hit;
         wire toggle_ok;

         assign action = output_action_mode[2*i+1:2*i]; // [R14]

         // A blocked tick hides a top match on channel A too, so the counter runs on
         assign hit = counter_tick & ~block_pending & (counter_value == active_value); // [R9] [R10]

         // Force is a plain strobe gated by the mode, never stored
         assign force_hit = force_match_strobe[i] & ~is_pwm; // [R7] [R22]

         // Toggle in PWM modes exists only on the channel that can define top
         assign toggle_ok = (i == 0) & toggle_allowed;

         assign compare_active[`TOCU_WIDTH*i+`TOCU_WIDTH-1:`TOCU_WIDTH*i] = active_value;

         // Reads see the register the CPU writes, never the temporary byte
         assign compare_read[`TOCU_WIDTH*i+`TOCU_WIDTH-1:`TOCU_WIDTH*i] =
            buffered ? buffer_value : active_value; // [R4] [R5]

         assign force_read[i] = 1'b0; // [R22]

         //////////////////////////////////////////////////////////////////////
         // Compare value storage, changed only by CPU writes and the transfer
         always @(posedge clk or negedge reset_n) begin
            if (!reset_n) begin
               buffer_value <= `TOCU_COMPARE_RESET;
               active_value <= `TOCU_COMPARE_RESET;
            end else begin
               if (buffered & update_point) begin
                  active_value <= buffer_value; // [R3]
               end
               if (cpu_write_low[i]) begin
                  buffer_value <= write_word; // [R4] [R5] [R6]
                  if (!buffered) begin
                     active_value <= write_word; // [R4]
                  end
               end
            end
         end

         //////////////////////////////////////////////////////////////////////
         // Match flag one timer tick after the match; set beats clear
         always @(posedge clk or negedge reset_n) begin
            if (!reset_n) begin
               pending <= 1'b0;
               match_flag[i] <= 1'b0;
               match_event[i] <= 1'b0;
            end else begin
               match_event[i] <= hit; // [R8]
               if (hit) begin
                  pending <= 1'b1;
               end else if (counter_tick) begin
                  pending <= 1'b0;
               end
               if (pending & counter_tick) begin
                  match_flag[i] <= 1'b1; // [R21]
               end else if (match_flag_clear[i]) begin
                  match_flag[i] <= 1'b0;
               end
            end
         end

         //////////////////////////////////////////////////////////////////////
         // Output state action
         always @* begin
            next_state = channel_output_state[i];
            if (!is_pwm) begin
               if (hit | force_hit) begin
                  case (action) // [R19]
                     `TOCU_ACT_TOGGLE: next_state = ~channel_output_state[i];
                     `TOCU_ACT_CLEAR: next_state = 1'b0;
                     `TOCU_ACT_SET: next_state = 1'b1;
                     default: next_state = channel_output_state[i]; // [R18]
                  endcase
               end
            end else if (is_fast) begin
               // Match takes priority over the bottom event when both occur
               case (action)
                  `TOCU_ACT_TOGGLE: begin
                     if (hit & toggle_ok) begin
                        next_state = ~channel_output_state[i];
                     end
                  end
                  `TOCU_ACT_CLEAR: begin
                     if (hit) begin
                        next_state = 1'b0;
                     end else if (bottom_event) begin
                        next_state = 1'b1;
                     end
                  end
                  `TOCU_ACT_SET: begin
                     if (hit) begin
                        next_state = 1'b1;
                     end else if (bottom_event) begin
                        next_state = 1'b0;
                     end
                  end
                  default: next_state = channel_output_state[i]; // [R18]
               endcase
            end else if (is_phase & hit) begin
               case (action)
                  `TOCU_ACT_TOGGLE: begin
                     if (toggle_ok) begin
                        next_state = ~channel_output_state[i];
                     end
                  end
                  `TOCU_ACT_CLEAR: next_state = counter_down;
                  `TOCU_ACT_SET: next_state = ~counter_down;
                  default: next_state = channel_output_state[i]; // [R18]
               endcase
            end
         end

         // No reload on mode change, so the state survives it
         always @(posedge clk or negedge reset_n) begin
            if (!reset_n) begin
               channel_output_state[i] <= `TOCU_STATE_RESET; // [R15]
            end else begin
               channel_output_state[i] <= next_state; // [R13]
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Pin override; input capture takes nothing from the mode field
   tocu_pin_mux #(
      .CHANNELS(CHANNELS)
   ) u_pins (
      .output_action_mode(output_action_mode), // [R20]
      .channel_output_state(channel_output_state),
      .port_output_value(port_output_value),
      .pin_direction_bit(pin_direction_bit),
      .pin_out(pin_out),
      .pin_oe(pin_oe)
   );

endmodule
`default_nettype wire

// ==== tocu_output_compare_monitor.sv ====
// Concurrent checks on the ports of the output compare unit.
// Assumes one clock domain and an active-low asynchronous reset.
`timescale 1ns/1ns
`default_nettype none
module tocu_oc_monitor #(
   parameter CHANNELS = 3
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [15:0] counter_value,
   input wire logic counter_tick,
   input wire logic counter_write,
   input wire logic [3:0] waveform_mode_select,
   input wire logic [2*CHANNELS-1:0] output_action_mode,
   input wire logic [CHANNELS-1:0] force_match_strobe,
   input wire logic [CHANNELS-1:0] cpu_write_low,
   input wire logic [7:0] cpu_write_data,
   input wire logic [CHANNELS-1:0] port_output_value,
   input wire logic [CHANNELS-1:0] pin_direction_bit,
   input wire logic [16*CHANNELS-1:0] compare_active,
   input wire logic [CHANNELS-1:0] force_read,
   input wire logic [CHANNELS-1:0] match_flag,
   input wire logic [CHANNELS-1:0] match_event,
   input wire logic [CHANNELS-1:0] channel_output_state,
   input wire logic [CHANNELS-1:0] pin_out,
   input wire logic [CHANNELS-1:0] pin_oe
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   ////////////////////////////////////////////////////////////////////////////////
   // Block tracker: a write arms it, the next timer tick consumes it
   logic blk;
   wire [CHANNELS-1:0] sel;
   wire hit0 = counter_tick && !blk && counter_value == compare_active[15:0];
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) blk <= 1'h0;
      else if (counter_write) blk <= 1'h1;
      else if (counter_tick) blk <= 1'h0;
   end
   for (genvar g = 0; g < CHANNELS; g++) begin : gs
      assign sel[g] = |output_action_mode[2*g+:2];
   end
   ////////////////////////////////////////////////////////////////////////////////
   a_event_hit: assert property (hit0 |=> match_event[0])
      else $error("match event missing");
   a_event_only: assert property (!hit0 |=> !match_event[0])
      else $error("match event without a counted hit");
   a_block_write: assert property (counter_tick && blk |=> match_event == '0)
      else $error("match not blocked after counter write");
   a_flag_tick: assert property ((match_flag & ~$past(match_flag)) != '0 |-> $past(counter_tick))
      else $error("flag set off a timer tick");
   a_off_hold: assert property (output_action_mode[1:0] == 2'h0 |=> $stable(channel_output_state[0]))
      else $error("state moved with action off");
   a_force_toggle: assert property (force_match_strobe[0] && !counter_tick && waveform_mode_select == 4'h0
      && output_action_mode[1:0] == 2'h1 |=> channel_output_state[0] != $past(channel_output_state[0]))
      else $error("forced toggle lost");
   a_pwm_buffer: assert property (cpu_write_low[1] && waveform_mode_select == 4'h5 && !counter_tick
      |=> $stable(compare_active[31:16]))
      else $error("buffered write reached active value");
   a_direct_write: assert property (cpu_write_low[0] && waveform_mode_select == 4'h0
      |=> compare_active[7:0] == $past(cpu_write_data))
      else $error("direct write not in active value");
   a_state_cause: assert property (channel_output_state != $past(channel_output_state)
      |-> $past(counter_tick || force_match_strobe != '0))
      else $error("state changed without cause");
   a_pin_dir: assert property (pin_oe == pin_direction_bit)
      else $error("pin enable differs from direction");
   a_pin_override: assert property (pin_out == ((sel & channel_output_state) | (~sel & port_output_value)))
      else $error("pin override wrong");
   a_force_read: assert property (force_read == '0)
      else $error("force strobe reads nonzero");
endmodule
bind tocu_output_compare tocu_oc_monitor #(.CHANNELS(CHANNELS)) i_tocu_oc_monitor (.clk(clk), .reset_n(reset_n),
   .counter_value(counter_value), .counter_tick(counter_tick), .counter_write(counter_write),
   .waveform_mode_select(waveform_mode_select), .output_action_mode(output_action_mode),
   .force_match_strobe(force_match_strobe), .cpu_write_low(cpu_write_low), .cpu_write_data(cpu_write_data),
   .port_output_value(port_output_value), .pin_direction_bit(pin_direction_bit),
   .compare_active(compare_active), .force_read(force_read), .match_flag(match_flag),
   .match_event(match_event), .channel_output_state(channel_output_state), .pin_out(pin_out), .pin_oe(pin_oe));
`default_nettype wire

// ==== tb_tocu_output_compare.sv ====
// Self-checking bench for the three-channel output compare unit.
// Assumes the bench stands in for counter, CPU and port; inputs change at falling edges.
`timescale 1ns/1ns
`default_nettype none
module tb_tocu_output_compare;
   logic clk = 1'h0;
   logic reset_n = 1'h0;
   logic [15:0] counter_value = 16'h0000;
   logic counter_tick = 1'h0, counter_write = 1'h0, counter_at_top = 1'h0, counter_at_bottom = 1'h0;
   logic cpu_write_high = 1'h0;
   logic [3:0] waveform_mode_select = 4'h0;
   logic [5:0] output_action_mode = 6'h00;
   logic [2:0] force_match_strobe = 3'h0, cpu_write_low = 3'h0, match_flag_clear = 3'h0;
   logic [2:0] port_output_value = 3'h0, pin_direction_bit = 3'h0;
   logic [7:0] cpu_write_data = 8'h00;
   wire [47:0] compare_read, compare_active;
   wire [2:0] force_read, match_flag, match_event, channel_output_state, pin_out, pin_oe;
   logic [15:0] cv [3] = '{16'h1234, 16'hab00, 16'h00ff};
   logic [1:0] act [4] = '{2'h3, 2'h2, 2'h1, 2'h0};
   logic st [4] = '{1'h1, 1'h0, 1'h1, 1'h1};
   logic [3:0] md [2] = '{4'h5, 4'h1};
   logic [15:0] nv [2] = '{16'h0102, 16'h0203};
   logic r [2] = '{1'h0, 1'h1};
   logic [15:0] old;
   int n_mismatch = 0;
   int comparisons = 0;
   int i;
   always #50 clk = ~clk;
   tocu_output_compare i_tocu_output_compare (.clk(clk), .reset_n(reset_n), .counter_value(counter_value),
      .counter_tick(counter_tick), .counter_write(counter_write), .counter_at_top(counter_at_top),
      .counter_at_bottom(counter_at_bottom), .counter_down(1'h0), .waveform_mode_select(waveform_mode_select),
      .output_action_mode(output_action_mode), .force_match_strobe(force_match_strobe),
      .cpu_write_high(cpu_write_high), .cpu_write_low(cpu_write_low), .cpu_write_data(cpu_write_data),
      .match_flag_clear(match_flag_clear), .port_output_value(port_output_value),
      .pin_direction_bit(pin_direction_bit), .compare_read(compare_read), .compare_active(compare_active),
      .force_read(force_read), .match_flag(match_flag), .match_event(match_event),
      .channel_output_state(channel_output_state), .pin_out(pin_out), .pin_oe(pin_oe));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [47:0] got, input logic [47:0] exp, input string what);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic wr16(input int ch, input logic [15:0] v);
      @(negedge clk);
      cpu_write_high = 1'h1;
      cpu_write_data = v[15:8];
      @(negedge clk);
      cpu_write_high = 1'h0;
      cpu_write_low[ch] = 1'h1;
      cpu_write_data = v[7:0];
      @(negedge clk);
      cpu_write_low = 3'h0;
   endtask
   task automatic tk(input logic [15:0] v, input logic top, input logic bot);
      @(negedge clk);
      counter_value = v;
      counter_tick = 1'h1;
      counter_at_top = top;
      counter_at_bottom = bot;
      @(negedge clk);
      counter_tick = 1'h0;
      counter_at_top = 1'h0;
      counter_at_bottom = 1'h0;
   endtask
   task automatic pulse(input int which, input logic [2:0] m);
      @(negedge clk);
      if (which == 0) force_match_strobe = m;
      else if (which == 1) match_flag_clear = m;
      else counter_write = 1'h1;
      @(negedge clk);
      force_match_strobe = 3'h0;
      match_flag_clear = 3'h0;
      counter_write = 1'h0;
   endtask
   task automatic report_and_stop;
      $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
      if (n_mismatch == 0 && comparisons > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // Whole run is under a hundred cycles; a thousand is ample
   initial begin
      #(100 * 1000);
      n_mismatch++;
      report_and_stop();
   end
   initial begin
      repeat (16) @(negedge clk);
      reset_n = 1'h1;
      chk({channel_output_state, match_flag, force_read}, 9'h000, "reset");
      for (i = 0; i < 3; i++) wr16(i, cv[i]);
      chk(compare_active, {cv[2], cv[1], cv[0]}, "direct write");
      chk(compare_read, {cv[2], cv[1], cv[0]}, "direct read");
      // Low byte alone picks up the shared high byte left by channel 2
      @(negedge clk);
      cpu_write_low = 3'h2;
      cpu_write_data = 8'h5a;
      @(negedge clk);
      cpu_write_low = 3'h0;
      chk(compare_active[31:16], 16'h005a, "shared temp");
      for (i = 0; i < 4; i++) begin
         output_action_mode = {4'h0, act[i]};
         pulse(0, 3'h1);
         chk(channel_output_state, {2'h0, st[i]}, "force action");
         chk({match_flag, match_event}, 6'h00, "force side effect");
      end
      output_action_mode = 6'h01;
      tk(16'h1234, 1'h0, 1'h0);
      chk({match_event, match_flag, channel_output_state}, 9'h040, "hit");
      tk(16'h0001, 1'h0, 1'h0);
      chk(match_flag, 3'h1, "flag next tick");
      pulse(1, 3'h1);
      chk(match_flag, 3'h0, "flag clear");
      // Timer stopped for a while after the counter write; first tick is still blocked
      // Counter only counts up here, so a bottom load while counting down never occurs
      pulse(2, 3'h0);
      repeat (3) @(negedge clk);
      tk(16'h1234, 1'h0, 1'h0);
      chk({match_event, channel_output_state}, 6'h00, "blocked");
      tk(16'h1234, 1'h0, 1'h0);
      chk({match_event, channel_output_state}, 6'h09, "unblocked");
      old = 16'h005a;
      output_action_mode = 6'h31;
      for (i = 0; i < 2; i++) begin
         waveform_mode_select = md[i];
         pulse(0, 3'h4);
         chk(channel_output_state, 3'h1, "pwm force ignored");
         wr16(1, nv[i]);
         chk(compare_read[31:16], nv[i], "buffer read");
         tk(16'h0400, ~r[i], r[i]);
         chk(compare_active[31:16], old, "no update");
         tk(16'h0400, r[i], ~r[i]);
         chk(compare_active[31:16], nv[i], "update");
         old = nv[i];
      end
      port_output_value = 3'h6;
      pin_direction_bit = 3'h5;
      #1;
      // State was set by the unblocked match in normal mode before any direction bit was raised
      chk({pin_out, pin_oe}, 6'h1d, "pin mux");
      report_and_stop();
   end
endmodule
`default_nettype wire
